// [rtl/bwd_top.v]
// board reset, watchdog and interrupt routing logic with register port
`include "bwd_defines.vh"

// Contract
// - enabled, unretriggered watchdog times out after 1400 ms, requesting reset
// - watchdog reset request lasts 200 ms, then ends by itself
// - software retrigger reloads the full timeout interval
// - strap gates watchdog into reset; open strap disables watchdog
// - board reset asserted by watchdog, manual contact or power monitor
// - board reset also driven onto the expansion bus connector
// - after reset release processor fetches at top vector, peripherals reset
// - route strap sends power-failure to nothing, non-maskable or irq zero
// - bus non-maskable raises cpu non-maskable; bus request raises irq zero
// - real-time clock periodic request drives cpu irq one
// - power-failure request precedes supply reset by about 100 us
module bwd_top
#(
    parameter [`BWD_CNT_W-1:0] WD_TIMEOUT_CYC = `BWD_WD_TIMEOUT_CYC,
    parameter [`BWD_CNT_W-1:0] WD_PULSE_CYC   = `BWD_WD_PULSE_CYC,
    parameter [`BWD_PF_CNT_W-1:0] PF_LEAD_CYC = `BWD_PF_LEAD_CYC
)
(
    input  wire                   I_CLOCK,
    input  wire                   I_RST,
    input  wire [`BWD_ADDR_W-1:0] I_ADDR,
    input  wire [`BWD_DATA_W-1:0] I_WDATA,
    input  wire                   I_WR,
    input  wire                   I_RD,
    output wire [`BWD_DATA_W-1:0] O_RDATA,
    input  wire                   I_WATCHDOG_ENABLE_STRAP,
    input  wire [1:0]             I_POWERFAIL_ROUTE_STRAP,
    input  wire                   I_MANUAL_RESET_CONTACT,
    input  wire                   I_POWER_GOOD,
    input  wire                   I_BUS_NMI_N,
    input  wire                   I_BUS_INT_N,
    input  wire                   I_RTC_IRQ_N,
    output wire                   O_BOARD_RESET_N,
    output wire                   O_BUS_RESET_N,
    output wire                   O_PERIPH_RESET,
    output wire                   O_FETCH_START,
    output wire [`BWD_VEC_W-1:0]  O_BOOT_VECTOR,
    output wire                   O_POWERFAIL,
    output wire                   O_CPU_NMI,
    output wire                   O_CPU_IRQ_ZERO,
    output wire                   O_CPU_IRQ_ONE
);

    ////////////////////////////////////////////////////////////////////////
    // decoding helper

    function addr_hit;
        input [`BWD_ADDR_W-1:0] addr;
        input [`BWD_ADDR_W-1:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    reg                    strap_valid_reg;
    reg                    wd_en_strap_reg;
    reg  [1:0]             pf_route_reg;
    reg  [`BWD_PF_CNT_W-1:0] pf_cnt_reg;
    reg  [`BWD_PF_CNT_W-1:0] pf_cnt_next;
    reg                    board_rst_reg;
    reg                    board_rst_next;
    reg                    fetch_start_reg;
    reg  [`BWD_VEC_W-1:0]  boot_vec_reg;
    reg                    pf_out_reg;
    reg                    nmi_reg;
    reg                    irq0_reg;
    reg                    irq1_reg;
    reg  [`BWD_DATA_W-1:0] rdata_reg;
    reg  [`BWD_DATA_W-1:0] rdata_next;
    reg  [`BWD_CAUSE_W-1:0] cause_reg;

    wire                   wr_ctrl;
    wire                   wr_cause;
    wire                   retrigger;
    wire                   wd_pulse;
    wire [`BWD_CNT_W-1:0]  wd_count;
    wire                   wd_rst;
    wire                   man_rst;
    wire                   pwr_rst;
    wire                   pf_req;
    wire                   other_rst;
    wire                   pf_to_nmi;
    wire                   pf_to_irq0;
    wire [`BWD_CAUSE_W-1:0] cause_set;
    wire [`BWD_CAUSE_W-1:0] cause_clr;
    wire [31:0]            wd_count_ext;

    ////////////////////////////////////////////////////////////////////////
    // strap capture
    // straps are caught after the reset release and again during every
    // board reset, never under the asynchronous reset itself

    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            strap_valid_reg <= 1'b0;
            wd_en_strap_reg <= 1'b0;
            pf_route_reg    <= `BWD_PF_OPEN;
        end
        else
        begin
            strap_valid_reg <= 1'b1;
            if (!strap_valid_reg || board_rst_reg)
            begin
                wd_en_strap_reg <= I_WATCHDOG_ENABLE_STRAP;
                pf_route_reg    <= I_POWERFAIL_ROUTE_STRAP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog

    assign wr_ctrl   = I_WR && addr_hit(I_ADDR, `BWD_ADDR_CTRL);
    assign retrigger = wr_ctrl && I_WDATA[`BWD_CTRL_RETRIG];

    // other reset sources restart the interval so software gets a full one
    assign other_rst = man_rst || pwr_rst;

    bwd_wdt
    #(
        .TIMEOUT_CYC (WD_TIMEOUT_CYC),
        .PULSE_CYC   (WD_PULSE_CYC)
    )
    u_wdt
    (
        .i_clk       (I_CLOCK),
        .i_rst       (I_RST),
        .i_enable    (wd_en_strap_reg),
        .i_retrigger (retrigger),
        .i_restart   (other_rst),
        .o_pulse     (wd_pulse),
        .o_count     (wd_count)
    );

    // strap gates the pulse into the reset circuit as well
    assign wd_rst = wd_pulse && wd_en_strap_reg;

    ////////////////////////////////////////////////////////////////////////
    // power monitor
    // power-fail asserts at once; supply reset follows after the lead time,
    // which is all the time the service routine gets

    assign pf_req  = !I_POWER_GOOD;
    assign pwr_rst = (pf_cnt_reg == PF_LEAD_CYC);

    always @*
    begin
        pf_cnt_next = pf_cnt_reg;
        if (I_POWER_GOOD)
            pf_cnt_next = {`BWD_PF_CNT_W{1'b0}};
        else if (pf_cnt_reg != PF_LEAD_CYC)
            pf_cnt_next = pf_cnt_reg + 1'b1;
    end

    // counter starts saturated: supply treated as bad until shown good
    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
            pf_cnt_reg <= PF_LEAD_CYC;
        else
            pf_cnt_reg <= pf_cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // board reset line

    assign man_rst = I_MANUAL_RESET_CONTACT;

    always @*
    begin
        board_rst_next = wd_rst || man_rst || pwr_rst;
    end

    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            board_rst_reg   <= 1'b1;
            fetch_start_reg <= 1'b0;
            boot_vec_reg    <= `BWD_RESET_VECTOR;
        end
        else
        begin
            board_rst_reg   <= board_rst_next;
            fetch_start_reg <= board_rst_reg && !board_rst_next;
            if (board_rst_reg)
                boot_vec_reg <= `BWD_RESET_VECTOR;
        end
    end

    assign O_BOARD_RESET_N = !board_rst_reg;
    assign O_BUS_RESET_N   = !board_rst_reg;
    assign O_PERIPH_RESET  = board_rst_reg;
    assign O_FETCH_START   = fetch_start_reg;
    assign O_BOOT_VECTOR   = boot_vec_reg;

    ////////////////////////////////////////////////////////////////////////
    // interrupt routing

    assign pf_to_nmi  = pf_req && (pf_route_reg == `BWD_PF_TO_NMI);
    assign pf_to_irq0 = pf_req && (pf_route_reg == `BWD_PF_TO_IRQ0);

    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pf_out_reg <= 1'b0;
            nmi_reg    <= 1'b0;
            irq0_reg   <= 1'b0;
            irq1_reg   <= 1'b0;
        end
        else
        begin
            pf_out_reg <= pf_req;
            nmi_reg    <= !I_BUS_NMI_N || pf_to_nmi;
            irq0_reg   <= !I_BUS_INT_N || pf_to_irq0;
            irq1_reg   <= !I_RTC_IRQ_N;
        end
    end

    assign O_POWERFAIL    = pf_out_reg;
    assign O_CPU_NMI      = nmi_reg;
    assign O_CPU_IRQ_ZERO = irq0_reg;
    assign O_CPU_IRQ_ONE  = irq1_reg;

    ////////////////////////////////////////////////////////////////////////
    // sticky reset cause flags
    // write one to clear; a source still active in that cycle keeps its flag

    assign wr_cause  = I_WR && addr_hit(I_ADDR, `BWD_ADDR_CAUSE);
    assign cause_set = {pwr_rst, man_rst, wd_rst};
    assign cause_clr = wr_cause ? I_WDATA[`BWD_CAUSE_W-1:0]
                                : {`BWD_CAUSE_W{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < `BWD_CAUSE_W; gi = gi + 1)
        begin : g_cause
            always @(posedge I_CLOCK or posedge I_RST)
            begin
                if (I_RST)
                    cause_reg[gi] <= 1'b0;
                else
                    cause_reg[gi] <= cause_set[gi] ||
                                     (cause_reg[gi] && !cause_clr[gi]);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register read port
    // data stand only in the cycle after the read strobe, zero otherwise

    assign wd_count_ext = {{(32-`BWD_CNT_W){1'b0}}, wd_count};

    always @*
    begin
        rdata_next = {`BWD_DATA_W{1'b0}};
        if (I_RD)
        begin
            if (addr_hit(I_ADDR, `BWD_ADDR_STATUS))
            begin
                rdata_next[`BWD_ST_WD_EN]     = wd_en_strap_reg;
                rdata_next[`BWD_ST_WD_PULSE]  = wd_pulse;
                rdata_next[`BWD_ST_PF]        = pf_req;
                rdata_next[`BWD_ST_BOARD_RST] = board_rst_reg;
                rdata_next[`BWD_ST_ROUTE_HI:`BWD_ST_ROUTE_LO] = pf_route_reg;
            end
            else if (addr_hit(I_ADDR, `BWD_ADDR_CAUSE))
                rdata_next[`BWD_CAUSE_W-1:0] = cause_reg;
            else if (addr_hit(I_ADDR, `BWD_ADDR_CNT0))
                rdata_next = wd_count_ext[7:0];
            else if (addr_hit(I_ADDR, `BWD_ADDR_CNT1))
                rdata_next = wd_count_ext[15:8];
            else if (addr_hit(I_ADDR, `BWD_ADDR_CNT2))
                rdata_next = wd_count_ext[23:16];
            else if (addr_hit(I_ADDR, `BWD_ADDR_CNT3))
                rdata_next = wd_count_ext[31:24];
        end
    end

    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
            rdata_reg <= {`BWD_DATA_W{1'b0}};
        else
            rdata_reg <= rdata_next;
    end

    assign O_RDATA = rdata_reg;

endmodule

// [pkg/bwd_defines.vh]
// constants shared by the board watchdog and reset/interrupt logic
`ifndef BWD_DEFINES_VH
`define BWD_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// clock and times in their own units
`define BWD_CLK_KHZ         125000
`define BWD_CLK_MHZ         125
`define BWD_WD_TIMEOUT_MS   1400
`define BWD_WD_PULSE_MS     200
`define BWD_PF_LEAD_US      100

// derived cycle counts
`define BWD_WD_TIMEOUT_CYC  (`BWD_WD_TIMEOUT_MS * `BWD_CLK_KHZ)
`define BWD_WD_PULSE_CYC    (`BWD_WD_PULSE_MS * `BWD_CLK_KHZ)
`define BWD_PF_LEAD_CYC     (`BWD_PF_LEAD_US * `BWD_CLK_MHZ)

// counter widths
`define BWD_CNT_W           28
`define BWD_PF_CNT_W        14

////////////////////////////////////////////////////////////////////////////
// processor restart address
`define BWD_RESET_VECTOR    24'hFFFFF0
`define BWD_VEC_W           24

////////////////////////////////////////////////////////////////////////////
// register port
`define BWD_ADDR_W          4
`define BWD_DATA_W          8
`define BWD_ADDR_CTRL       4'h0
`define BWD_ADDR_STATUS     4'h1
`define BWD_ADDR_CAUSE      4'h2
`define BWD_ADDR_CNT0       4'h3
`define BWD_ADDR_CNT1       4'h4
`define BWD_ADDR_CNT2       4'h5
`define BWD_ADDR_CNT3       4'h6

// control fields
`define BWD_CTRL_RETRIG     0

// status fields
`define BWD_ST_WD_EN        0
`define BWD_ST_WD_PULSE     1
`define BWD_ST_PF           2
`define BWD_ST_BOARD_RST    3
`define BWD_ST_ROUTE_LO     4
`define BWD_ST_ROUTE_HI     5

// sticky reset cause fields
`define BWD_CAUSE_W         3
`define BWD_CAUSE_WD        0
`define BWD_CAUSE_MAN       1
`define BWD_CAUSE_PWR       2

////////////////////////////////////////////////////////////////////////////
// power-failure route strap codes
`define BWD_PF_OPEN         2'h0
`define BWD_PF_TO_NMI       2'h1
`define BWD_PF_TO_IRQ0      2'h2

`endif

// [rtl/bwd_wdt.v]
// astable watchdog timer: timeout count, then self-ending reset pulse
`include "bwd_defines.vh"

module bwd_wdt
#(
    parameter [`BWD_CNT_W-1:0] TIMEOUT_CYC = `BWD_WD_TIMEOUT_CYC,
    parameter [`BWD_CNT_W-1:0] PULSE_CYC   = `BWD_WD_PULSE_CYC
)
(
    input  wire                  i_clk,
    input  wire                  i_rst,
    input  wire                  i_enable,
    input  wire                  i_retrigger,
    input  wire                  i_restart,
    output reg                   o_pulse,
    output reg  [`BWD_CNT_W-1:0] o_count
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_PULSE = 2'h2;

    reg [1:0]            state_reg;
    reg [1:0]            state_next;
    reg [`BWD_CNT_W-1:0] count_next;

    ////////////////////////////////////////////////////////////////////////
    always @*
    begin
        state_next = state_reg;
        count_next = o_count;
        case (state_reg)
            ST_IDLE:
            begin
                count_next = {`BWD_CNT_W{1'b0}};
                if (i_enable)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (!i_enable)
                begin
                    state_next = ST_IDLE;
                    count_next = {`BWD_CNT_W{1'b0}};
                end
                else if (i_retrigger || i_restart)
                    count_next = {`BWD_CNT_W{1'b0}};
                else if (o_count == TIMEOUT_CYC - 1'b1)
                begin
                    state_next = ST_PULSE;
                    count_next = {`BWD_CNT_W{1'b0}};
                end
                else
                    count_next = o_count + 1'b1;
            end
            ST_PULSE:
            begin
                // retrigger cannot cut the pulse short
                if (!i_enable)
                begin
                    state_next = ST_IDLE;
                    count_next = {`BWD_CNT_W{1'b0}};
                end
                else if (o_count == PULSE_CYC - 1'b1)
                begin
                    state_next = ST_RUN;
                    count_next = {`BWD_CNT_W{1'b0}};
                end
                else
                    count_next = o_count + 1'b1;
            end
            default:
            begin
                state_next = ST_IDLE;
                count_next = {`BWD_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            o_count   <= {`BWD_CNT_W{1'b0}};
            o_pulse   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            o_count   <= count_next;
            o_pulse   <= (state_next == ST_PULSE);
        end
    end

endmodule

// [test/bwd_chk_assertions.sv]
// concurrent checks on the board reset and interrupt routing ports
`include "bwd_defines.vh"
module bwd_chk
#(
    parameter [`BWD_CNT_W-1:0]    WD_TIMEOUT_CYC = `BWD_WD_TIMEOUT_CYC,
    parameter [`BWD_CNT_W-1:0]    WD_PULSE_CYC   = `BWD_WD_PULSE_CYC,
    parameter [`BWD_PF_CNT_W-1:0] PF_LEAD_CYC    = `BWD_PF_LEAD_CYC
)
(
    input wire                  I_CLOCK,
    input wire                  I_RST,
    input wire [1:0]            I_POWERFAIL_ROUTE_STRAP,
    input wire                  I_MANUAL_RESET_CONTACT,
    input wire                  I_POWER_GOOD,
    input wire                  I_BUS_NMI_N,
    input wire                  I_BUS_INT_N,
    input wire                  I_RTC_IRQ_N,
    input wire                  O_BOARD_RESET_N,
    input wire                  O_BUS_RESET_N,
    input wire                  O_PERIPH_RESET,
    input wire                  O_FETCH_START,
    input wire [`BWD_VEC_W-1:0] O_BOOT_VECTOR,
    input wire                  O_POWERFAIL,
    input wire                  O_CPU_NMI,
    input wire                  O_CPU_IRQ_ZERO,
    input wire                  O_CPU_IRQ_ONE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    ////////////////////////////////////////////////////////////////////////
    // low-time counter; other sources mark the pulse as not watchdog-only
    logic [`BWD_CNT_W-1:0] low_cnt_reg;
    logic                  ext_reg;
    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            low_cnt_reg <= '0;
            ext_reg     <= 1'b1;
        end
        else if (O_BOARD_RESET_N)
        begin
            low_cnt_reg <= '0;
            ext_reg     <= 1'b0;
        end
        else
        begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
            ext_reg <= ext_reg | I_MANUAL_RESET_CONTACT | !I_POWER_GOOD;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_wd_pulse;
        $rose(O_BOARD_RESET_N) && !ext_reg |-> low_cnt_reg == WD_PULSE_CYC;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog reset pulse has wrong length");
    property p_bus_rst;
        O_BUS_RESET_N == O_BOARD_RESET_N;
    endproperty
    a_bus_rst: assert property (p_bus_rst)
        else $error("bus reset differs from board reset");
    property p_periph;
        O_PERIPH_RESET == !O_BOARD_RESET_N;
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral reset differs from board reset");
    property p_fetch;
        $rose(O_BOARD_RESET_N) |->
            O_FETCH_START && O_BOOT_VECTOR == `BWD_RESET_VECTOR;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("no fetch from top vector after reset release");
    property p_man;
        I_MANUAL_RESET_CONTACT [*4] |-> !O_BOARD_RESET_N;
    endproperty
    a_man: assert property (p_man)
        else $error("closed contact does not reset the board");
    property p_pf_hold;
        $rose(O_POWERFAIL) && O_BOARD_RESET_N |-> O_BOARD_RESET_N [*8];
    endproperty
    a_pf_hold: assert property (p_pf_hold)
        else $error("power-fail request not ahead of supply reset");
    // run length of the power-fail request, saturating
    logic [`BWD_PF_CNT_W-1:0] pf_run_reg;
    always @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
            pf_run_reg <= '0;
        else if (!O_POWERFAIL)
            pf_run_reg <= '0;
        else if (pf_run_reg != '1)
            pf_run_reg <= pf_run_reg + 1'b1;
    end
    property p_pf_rst;
        pf_run_reg > PF_LEAD_CYC |-> !O_BOARD_RESET_N;
    endproperty
    a_pf_rst: assert property (p_pf_rst)
        else $error("supply failure does not reset the board");
    property p_pf;
        !$past(I_RST) |-> O_POWERFAIL == !$past(I_POWER_GOOD);
    endproperty
    a_pf: assert property (p_pf)
        else $error("power-fail request does not follow supply");
    property p_nmi;
        !$past(I_RST) |-> O_CPU_NMI == (!$past(I_BUS_NMI_N) ||
            (O_POWERFAIL && $past(I_POWERFAIL_ROUTE_STRAP) == 2'h1));
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("non-maskable output wrong");
    property p_irq0;
        !$past(I_RST) |-> O_CPU_IRQ_ZERO == (!$past(I_BUS_INT_N) ||
            (O_POWERFAIL && $past(I_POWERFAIL_ROUTE_STRAP) == 2'h2));
    endproperty
    a_irq0: assert property (p_irq0)
        else $error("interrupt zero output wrong");
    property p_irq1;
        !$past(I_RST) |-> O_CPU_IRQ_ONE == !$past(I_RTC_IRQ_N);
    endproperty
    a_irq1: assert property (p_irq1)
        else $error("interrupt one output wrong");
endmodule

bind bwd_top bwd_chk
#(
    .WD_TIMEOUT_CYC (WD_TIMEOUT_CYC),
    .WD_PULSE_CYC   (WD_PULSE_CYC),
    .PF_LEAD_CYC    (PF_LEAD_CYC)
)
u_chk
(
    .I_CLOCK, .I_RST, .I_POWERFAIL_ROUTE_STRAP, .I_MANUAL_RESET_CONTACT,
    .I_POWER_GOOD, .I_BUS_NMI_N, .I_BUS_INT_N, .I_RTC_IRQ_N,
    .O_BOARD_RESET_N, .O_BUS_RESET_N, .O_PERIPH_RESET, .O_FETCH_START,
    .O_BOOT_VECTOR, .O_POWERFAIL, .O_CPU_NMI, .O_CPU_IRQ_ZERO,
    .O_CPU_IRQ_ONE
);

// [test/bwd_far_model.sv]
// expansion cards and clock chip raising their active-low requests
module bwd_far_model
(
    input  wire       i_clk,
    input  wire       i_bus_reset_n,
    input  wire [2:0] i_req,
    output logic      o_bus_nmi_n = 1'b1,
    output logic      o_bus_int_n = 1'b1,
    output logic      o_rtc_irq_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // cards held in reset let their pulled-up request lines float high
    always @(posedge i_clk)
    begin
        o_bus_nmi_n <= !(i_req[0] && i_bus_reset_n);
        o_bus_int_n <= !(i_req[1] && i_bus_reset_n);
        o_rtc_irq_n <= !i_req[2];
    end
endmodule

// [test/testbench.sv]
// self-checking bench for the board reset, watchdog and interrupt block
`include "bwd_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 200;
    localparam int P = 20;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
    logic       wds = 1'b0, man = 1'b0, pgood = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, lfsr_reg = 8'h2F;
    logic [1:0] route = 2'h0;
    logic [2:0] req = 3'h0;
    wire  [7:0] rdata;
    wire [23:0] vec;
    wire        nmi_n, int_n, rtc_n, brst_n, bus_rst_n, prst, fetch;
    wire        pf, nmi, irq0, irq1;
    logic [7:0] exp_q[$];
    int         err_count = 0, compares = 0, n = 0;

    bwd_top #(.WD_TIMEOUT_CYC(T), .WD_PULSE_CYC(P), .PF_LEAD_CYC(10)) dut (
        .I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_WATCHDOG_ENABLE_STRAP(wds), .I_POWERFAIL_ROUTE_STRAP(route),
        .I_MANUAL_RESET_CONTACT(man), .I_POWER_GOOD(pgood),
        .I_BUS_NMI_N(nmi_n), .I_BUS_INT_N(int_n), .I_RTC_IRQ_N(rtc_n),
        .O_BOARD_RESET_N(brst_n), .O_BUS_RESET_N(bus_rst_n),
        .O_PERIPH_RESET(prst), .O_FETCH_START(fetch), .O_BOOT_VECTOR(vec),
        .O_POWERFAIL(pf), .O_CPU_NMI(nmi), .O_CPU_IRQ_ZERO(irq0),
        .O_CPU_IRQ_ONE(irq1));
    bwd_far_model far (.i_clk(clk), .i_bus_reset_n(bus_rst_n), .i_req(req),
        .o_bus_nmi_n(nmi_n), .o_bus_int_n(int_n), .o_rtc_irq_n(rtc_n));

    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic cmp_pin(input logic [23:0] got, input logic [23:0] e);
        compares++;
        if (got !== e)
        begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, e);
        end
    endtask
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
        cmp_pin({16'h0000, got}, {16'h0000, e});
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // bounded wait for the board reset line to reach a level
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (brst_n !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // straps are only taken while the board is held in reset
    task automatic mreset(input logic s, input logic [1:0] r);
        @(posedge clk);
        wds   <= s;
        route <= r;
        man   <= 1'b1;
        repeat (6) @(posedge clk);
        man <= 1'b0;
        wait_rst(1'b1, 20);
        cmp_pin(brst_n, 1'b1);
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
            cmp_rd(rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    initial
    begin
        #(8 * 40000);
        err_count++;
        $display("mismatch at %0t: run timed out", $time);
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_rst(1'b1, 20);
        cmp_pin(vec, `BWD_RESET_VECTOR);
        cmp_pin({bus_rst_n, prst}, 2'b10);
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, 8'h00);
        $display("test reset done");
        for (int r = 0; r < 4; r++)
        begin
            wr_reg(`BWD_ADDR_CAUSE, 8'h07);
            mreset(1'b0, r[1:0]);
            rd_reg(`BWD_ADDR_CAUSE, 8'h02);
            rd_reg(`BWD_ADDR_STATUS, {2'b00, r[1:0], 4'h0});
            repeat (6)
            begin
                lfsr_reg = lfsr(lfsr_reg);
                @(posedge clk);
                req <= lfsr_reg[2:0];
                repeat (3) @(posedge clk);
                #1;
                cmp_pin({irq1, irq0, nmi}, lfsr_reg[2:0]);
            end
            @(posedge clk);
            req   <= 3'h0;
            pgood <= 1'b0;
            repeat (4) @(posedge clk);
            #1;
            cmp_pin({pf, nmi, irq0}, {1'b1, r == 1, r == 2});
            wait_rst(1'b0, 40);
            cmp_pin(brst_n, 1'b0);
            @(posedge clk);
            pgood <= 1'b1;
            wait_rst(1'b1, 20);
            rd_reg(`BWD_ADDR_CAUSE, 8'h06);
            $display("test route %0d done", r);
        end
        wait_rst(1'b0, 2 * T);
        cmp_pin(brst_n, 1'b1);
        mreset(1'b1, 2'h0);
        wr_reg(`BWD_ADDR_CAUSE, 8'h07);
        repeat (4)
        begin
            wr_reg(`BWD_ADDR_CTRL, 8'h01);
            rd_reg(`BWD_ADDR_CNT0, 8'h01);
            wait_rst(1'b0, T / 2);
            cmp_pin(brst_n, 1'b1);
        end
        wr_reg(`BWD_ADDR_CTRL, 8'h01);
        wait_rst(1'b0, 2 * T);
        cmp_pin(n >= T - 1 && n <= T + 3, 1'b1);
        repeat (P / 2) @(posedge clk);
        rd_reg(`BWD_ADDR_STATUS, 8'h0B);
        wait_rst(1'b1, 2 * P);
        wait_rst(1'b0, 2 * T);
        cmp_pin(n >= T - 2 && n <= T + 2, 1'b1);
        rd_reg(`BWD_ADDR_CAUSE, 8'h01);
        wr_reg(`BWD_ADDR_CTRL, 8'h01);
        wait_rst(1'b1, 2 * P);
        cmp_pin(brst_n, 1'b1);
        $display("test watchdog done");
        test_done;
    end
endmodule
